// [design/secp_core.sv]
// command decoder, status byte and write protection of the serial eeprom
`default_nettype none

module secp_core
	import secp_pkg::*;
#(
	parameter int   WRITE_CYCLES_P = WRITE_CYCLES,
	parameter logic ID_PAGE_EN     = 1'b1
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	// serial pins
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       wp_n,
	output logic            miso,
	output logic            miso_oe,
	// array and id page datapath
	output secp_cmd_t       cmd,
	output secp_byte_t      wr_byte,
	input  wire logic [7:0] rd_data,
	// state view
	output logic [7:0]      status_byte,
	output logic            hardware_lock_mode,
	output logic            software_lock_mode
);

	typedef struct packed {
		secp_state_t st;
		secp_kind_t  kind;
		logic [7:0]  in_sr;
		logic [2:0]  bit_cnt;
		logic [2:0]  byte_cnt;
		logic [15:0] addr;
		logic [7:0]  data0;
		logic [7:0]  out_sr;
		logic [2:0]  out_cnt;
		logic        out_live;
		logic        miso;
		logic        cs_seen_high;
		logic        write_enable_latch;
		logic [1:0]  protect_sel;
		logic        status_lock_bit;
		logic        pend_status;
		logic [7:0]  pend_byte;
		secp_cmd_t   cmd;
		secp_byte_t  wr;
	} secp_core_t;

	secp_core_t r;
	secp_core_t n;

	secp_pins_t pins_in;
	secp_pins_t pins_lvl;
	secp_pins_t pins_rise;
	secp_pins_t pins_fall;
	logic       busy;
	logic       done;
	logic       start_c;
	logic       hw_lock;

	// ==========================================================
	// pin synchronisers; chip select and protect idle high
	assign pins_in = '{cs_n: cs_n, sck: sck, mosi: mosi, wp_n: wp_n};

	secp_pin_sync #(
		.W         (4),
		.RESET_VAL (4'h9)
	) u_sync (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.async_in (pins_in),
		.level    (pins_lvl),
		.rise     (pins_rise),
		.fall     (pins_fall)
	);

	secp_write_timer #(
		.CYCLES (WRITE_CYCLES_P)
	) u_timer (
		.sys_clk (sys_clk),
		.srst    (srst),
		.start   (start_c),
		.busy    (busy),
		.done    (done)
	);

	// ==========================================================
	// status view
	assign hw_lock = r.status_lock_bit & ~pins_lvl.wp_n;

	always_comb begin
		status_byte                 = 8'h00;
		// busy covers the completion cycle so protect, lock and latch move as busy falls
		status_byte[ST_BUSY_BIT]    = busy | done;
		status_byte[ST_LATCH_BIT]   = r.write_enable_latch;
		status_byte[ST_PROT_LO_BIT] = r.protect_sel[0];
		status_byte[ST_PROT_HI_BIT] = r.protect_sel[1];
		status_byte[ST_LOCK_BIT]    = r.status_lock_bit;
	end

	// ==========================================================
	// main sequencer
	always_comb begin
		logic [7:0] sr;
		logic       byte_done;
		logic       aligned;
		logic [7:0] ld;
		sr        = {r.in_sr[6:0], pins_lvl.mosi};
		byte_done = 1'b0;
		aligned   = 1'b0;
		ld        = 8'h00;
		n         = r;
		start_c   = 1'b0;
		n.cmd.valid = 1'b0;
		n.wr.valid  = 1'b0;

		// completion of a self-timed cycle
		if (done) begin
			if (r.pend_status) begin
				n.protect_sel     = {r.pend_byte[ST_PROT_HI_BIT], r.pend_byte[ST_PROT_LO_BIT]};
				n.status_lock_bit = r.pend_byte[ST_LOCK_BIT];
				n.pend_status     = 1'b0;
			end
			n.write_enable_latch = 1'b0;
		end
		if (pins_lvl.cs_n) begin
			n.cs_seen_high = 1'b1;
		end

		unique case (r.st)
			ST_IDLE: begin
				// a low select at reset release still selects, as the synchroniser level resets high
				if (pins_fall.cs_n && r.cs_seen_high) begin
					n.st       = ST_OPCODE;
					n.bit_cnt  = 3'h0;
					n.byte_cnt = 3'h0;
					n.out_cnt  = 3'h0;
					n.out_live = 1'b0;
				end
			end
			ST_IGNORE: begin
				if (pins_rise.cs_n) begin
					n.st = ST_IDLE;
				end
			end
			default: begin
				// bit capture on rising clock, msb first
				if (pins_rise.sck) begin
					n.in_sr   = sr;
					n.bit_cnt = r.bit_cnt + 3'h1;
					if (r.bit_cnt == LAST_BIT) begin
						byte_done = 1'b1;
						if (r.byte_cnt != BYTE_CNT_MAX) begin
							n.byte_cnt = r.byte_cnt + 3'h1;
						end
					end
				end
				unique case (r.st)
					ST_OPCODE: begin
						if (byte_done) begin
							n.st = ST_IGNORE;
							unique case (sr)
								LATCH_SET_CMD: begin
									n.kind = KIND_LATCH_SET;
									n.st   = busy ? ST_IGNORE : ST_WAIT_CS;
								end
								LATCH_CLEAR_CMD: begin
									n.kind = KIND_LATCH_CLEAR;
									n.st   = busy ? ST_IGNORE : ST_WAIT_CS;
								end
								STATUS_READ_CMD: begin
									n.kind = KIND_STATUS_READ;
									n.st   = ST_STREAM;
								end
								STATUS_WRITE_CMD: begin
									n.kind = KIND_STATUS_WRITE;
									n.st   = busy ? ST_IGNORE : ST_DATA;
								end
								ARRAY_READ_CMD: begin
									n.kind = KIND_ARRAY_READ;
									n.st   = busy ? ST_IGNORE : ST_ADDR;
								end
								ARRAY_WRITE_CMD: begin
									n.kind = KIND_ARRAY_WRITE;
									n.st   = busy ? ST_IGNORE : ST_ADDR;
								end
								ID_READ_CMD: begin
									n.kind = KIND_ID_READ;
									n.st   = (busy || !ID_PAGE_EN) ? ST_IGNORE : ST_ADDR;
								end
								ID_WRITE_CMD: begin
									n.kind = KIND_ID_WRITE;
									n.st   = (busy || !ID_PAGE_EN) ? ST_IGNORE : ST_ADDR;
								end
								default: n.st = ST_IGNORE;
							endcase
						end
					end
					ST_ADDR: begin
						if (byte_done) begin
							n.addr = {r.addr[7:0], sr};
							if (n.byte_cnt == ADDR_END_BYTES) begin
								if (r.kind == KIND_ID_READ && n.addr[ID_SELECT_ADDR_BIT]) begin
									n.kind = KIND_LOCK_STATUS;
								end
								if (r.kind == KIND_ID_WRITE && n.addr[ID_SELECT_ADDR_BIT]) begin
									n.kind = KIND_ID_LOCK;
								end
								if (r.kind == KIND_ARRAY_READ || r.kind == KIND_ID_READ) begin
									n.st        = ST_STREAM;
									n.cmd.valid = 1'b1;
									n.cmd.kind  = n.kind;
									n.cmd.addr  = n.addr;
								end else begin
									n.st = ST_DATA;
								end
							end
						end
					end
					ST_DATA: begin
						if (byte_done) begin
							if (r.kind == KIND_STATUS_WRITE) begin
								n.data0 = sr;
							end else begin
								n.wr.valid = 1'b1;
								n.wr.data  = sr;
							end
						end
					end
					ST_WAIT_CS: begin
						// any clock past the opcode spoils the command
						if (pins_rise.sck) begin
							n.st = ST_IGNORE;
						end
					end
					ST_STREAM: begin
						if (pins_fall.sck) begin
							n.out_live = 1'b1;
							if (r.out_cnt == 3'h0) begin
								ld = (r.kind == KIND_STATUS_READ) ? status_byte : rd_data;
								n.miso    = ld[7];
								n.out_sr  = {ld[6:0], 1'b0};
								n.out_cnt = 3'h7;
								if (r.kind != KIND_STATUS_READ) begin
									n.addr      = r.addr + 16'h0001;
									n.cmd.valid = 1'b1;
									n.cmd.kind  = r.kind;
									n.cmd.addr  = r.addr + 16'h0001;
								end
							end else begin
								n.miso    = r.out_sr[7];
								n.out_sr  = {r.out_sr[6:0], 1'b0};
								n.out_cnt = r.out_cnt - 3'h1;
							end
						end
					end
					default: n.st = ST_IGNORE;
				endcase

				// execution on chip select release
				if (pins_rise.cs_n) begin
					aligned    = (n.bit_cnt == 3'h0);
					n.st       = ST_IDLE;
					n.out_live = 1'b0;
					if (aligned && r.st == ST_WAIT_CS && n.byte_cnt == OPCODE_BYTES) begin
						if (r.kind == KIND_LATCH_SET) begin
							n.write_enable_latch = 1'b1;
						end else begin
							n.write_enable_latch = 1'b0;
						end
					end
					if (aligned && r.st == ST_DATA && r.write_enable_latch) begin
						if (r.kind == KIND_STATUS_WRITE) begin
							if (n.byte_cnt == STATUS_WR_BYTES && !hw_lock) begin
								start_c       = 1'b1;
								n.pend_status = 1'b1;
								n.pend_byte   = n.data0;
							end
						end else if (n.byte_cnt >= ARRAY_WR_BYTES) begin
							if (r.kind != KIND_ARRAY_WRITE || !secp_in_protected(r.addr, r.protect_sel)) begin
								start_c     = 1'b1;
								n.cmd.valid = 1'b1;
								n.cmd.kind  = r.kind;
								n.cmd.addr  = r.addr;
							end
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			r                    <= '0;
			r.write_enable_latch <= WEL_RESET;
			r.protect_sel        <= PROTECT_SEL_RESET;
			r.status_lock_bit    <= STATUS_LOCK_RESET;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// outputs
	assign miso               = r.miso;
	assign miso_oe            = r.out_live;
	assign cmd                = r.cmd;
	assign wr_byte            = r.wr;
	assign software_lock_mode = (r.protect_sel != 2'h0) & ~hw_lock;
	assign hardware_lock_mode = hw_lock;

endmodule : secp_core

`default_nettype wire

// [design/secp_pkg.sv]
// constants, types and helpers shared by the serial eeprom command and protection block
// What this block does
// - first byte after select is opcode; latch set 06h, latch clear 04h, status read 05h.
// - opcode 01h is status write, 03h array read, 02h array write.
// - id variant: 83h reads id page when address bit 10 clear, lock status when set.
// - id variant: 82h writes id page when bit 10 clear, freezes it when set.
// - unsupported opcode deselects device until chip select is released and reasserted.
// - array and status writes need a clock count that is a multiple of eight.
// - chip select must rise after the final bit edge and before the next one.
// - final bit is eighth opcode or data bit; both reads are exempt from this check.
// - master sends latch set before every array or status write; only way to set.
// - after latch set opcode wait for chip select high, then set the latch.
// - latch clears on reset, latch clear command, and completion of any write.
// - with latch at zero every array write and status write is rejected.
// - status read works any time, even while busy, and repeats while selected.
// - busy flag reads one while an array or status write cycle runs.
// - protect field is kept, changed only by status write outside hardware lock.
// - protect 00 none, 01 C000h-FFFFh, 10 8000h-FFFFh, 11 0000h-FFFFh.
// - array writes into the protected region are refused.
// - lock bit set with protect pin low gives hardware lock; status writes refused.
// - inputs sampled msb first on rising clock edges from the first after select.
// - read data driven msb first from falling clock edges after the read opcode.
// - after reset the device stays unselected until a falling chip select edge; a select held low at reset release also selects.
// - busy during the self-timed write; completion clears busy and the latch.
`default_nettype none

package secp_pkg;

	// ==========================================================
	// opcodes
	localparam logic [7:0] LATCH_SET_CMD    = 8'h06;
	localparam logic [7:0] LATCH_CLEAR_CMD  = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] ARRAY_READ_CMD   = 8'h03;
	localparam logic [7:0] ARRAY_WRITE_CMD  = 8'h02;
	localparam logic [7:0] ID_READ_CMD      = 8'h83;
	localparam logic [7:0] ID_WRITE_CMD     = 8'h82;
	localparam int         ID_SELECT_ADDR_BIT = 10;

	// ==========================================================
	// status byte layout and reset values
	localparam int         ST_BUSY_BIT    = 0;
	localparam int         ST_LATCH_BIT   = 1;
	localparam int         ST_PROT_LO_BIT = 2;
	localparam int         ST_PROT_HI_BIT = 3;
	localparam int         ST_LOCK_BIT    = 7;
	localparam logic       WEL_RESET         = 1'b0;
	localparam logic [1:0] PROTECT_SEL_RESET = 2'h0;
	localparam logic       STATUS_LOCK_RESET = 1'b0;

	// ==========================================================
	// protected region bases
	localparam logic [15:0] PROT_QUARTER_BASE = 16'hC000;
	localparam logic [15:0] PROT_HALF_BASE    = 16'h8000;
	localparam logic [15:0] PROT_WHOLE_BASE   = 16'h0000;

	// ==========================================================
	// byte counts within one selection (opcode counts as the first)
	localparam logic [2:0] OPCODE_BYTES    = 3'h1;
	localparam logic [2:0] STATUS_WR_BYTES = 3'h2;
	localparam logic [2:0] ADDR_END_BYTES  = 3'h3;
	localparam logic [2:0] ARRAY_WR_BYTES  = 3'h4;
	localparam logic [2:0] BYTE_CNT_MAX    = 3'h7;
	localparam logic [2:0] LAST_BIT        = 3'h7;

	// ==========================================================
	// timing
	localparam int CLK_MHZ        = 100;
	localparam int WRITE_TIME_US  = 5000;
	localparam int WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_OPCODE  = 3'h1,
		ST_ADDR    = 3'h2,
		ST_DATA    = 3'h3,
		ST_STREAM  = 3'h4,
		ST_WAIT_CS = 3'h5,
		ST_IGNORE  = 3'h6
	} secp_state_t;

	typedef enum logic [3:0] {
		KIND_LATCH_SET    = 4'h0,
		KIND_LATCH_CLEAR  = 4'h1,
		KIND_STATUS_READ  = 4'h2,
		KIND_STATUS_WRITE = 4'h3,
		KIND_ARRAY_READ   = 4'h4,
		KIND_ARRAY_WRITE  = 4'h5,
		KIND_ID_READ      = 4'h6,
		KIND_ID_WRITE     = 4'h7,
		KIND_ID_LOCK      = 4'h8,
		KIND_LOCK_STATUS  = 4'h9
	} secp_kind_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic mosi;
		logic wp_n;
	} secp_pins_t;

	typedef struct packed {
		logic        valid;
		secp_kind_t  kind;
		logic [15:0] addr;
	} secp_cmd_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} secp_byte_t;

	// ==========================================================
	// protected region decode
	function automatic logic secp_in_protected(input logic [15:0] a, input logic [1:0] bp);
		logic hit;
		hit = 1'b0;
		unique case (bp)
			2'h0: hit = 1'b0;
			2'h1: hit = (a >= PROT_QUARTER_BASE);
			2'h2: hit = (a >= PROT_HALF_BASE);
			2'h3: hit = (a >= PROT_WHOLE_BASE);
		endcase
		return hit;
	endfunction : secp_in_protected

endpackage : secp_pkg

`default_nettype wire

// [design/secp_pin_sync.sv]
// two-flop synchroniser with edge detection for asynchronous pins
`default_nettype none

module secp_pin_sync #(
	parameter int            W         = 4,
	parameter logic [W-1:0]  RESET_VAL = '0
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         srst,
	// pins
	input  wire logic [W-1:0] async_in,
	// synchronised view
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] prev;
	} secp_sync_t;

	secp_sync_t sync_reg;
	secp_sync_t sync_next;

	// ==========================================================
	// first stage feeds only the second
	always_comb begin
		sync_next      = sync_reg;
		sync_next.s1   = async_in;
		sync_next.s2   = sync_reg.s1;
		sync_next.prev = sync_reg.s2;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync_reg <= '{s1: RESET_VAL, s2: RESET_VAL, prev: RESET_VAL};
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign level = sync_reg.s2;
	assign rise  = sync_reg.s2 & ~sync_reg.prev;
	assign fall  = ~sync_reg.s2 & sync_reg.prev;

endmodule : secp_pin_sync

`default_nettype wire

// [design/secp_write_timer.sv]
// self-timed write cycle counter
`default_nettype none

module secp_write_timer #(
	parameter int CYCLES = 500000
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic srst,
	// control
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	typedef struct packed {
		logic          busy;
		logic          done;
		logic [CW-1:0] cnt;
	} secp_timer_t;

	secp_timer_t tm_reg;
	secp_timer_t tm_next;

	// ==========================================================
	// start is ignored while a cycle runs
	always_comb begin
		tm_next      = tm_reg;
		tm_next.done = 1'b0;
		if (tm_reg.busy) begin
			if (tm_reg.cnt == LAST) begin
				tm_next.busy = 1'b0;
				tm_next.done = 1'b1;
			end else begin
				tm_next.cnt = tm_reg.cnt + CW'(1);
			end
		end else if (start) begin
			tm_next.busy = 1'b1;
			tm_next.cnt  = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tm_reg <= '0;
		end else begin
			tm_reg <= tm_next;
		end
	end

	assign busy = tm_reg.busy;
	assign done = tm_reg.done;

endmodule : secp_write_timer

`default_nettype wire

// [sim/secp_core_asserts.sv]
// concurrent checks on the ports of the command and protection block
`default_nettype none
module secp_core_asserts
	import secp_pkg::*;
#(
	parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       srst,
	// serial pins
	input wire logic       cs_n,
	input wire logic       sck,
	input wire logic       mosi,
	input wire logic       wp_n,
	input wire logic       miso,
	input wire logic       miso_oe,
	// datapath
	input wire secp_cmd_t  cmd,
	input wire secp_byte_t wr_byte,
	input wire logic [7:0] rd_data,
	// state view
	input wire logic [7:0] status_byte,
	input wire logic       hardware_lock_mode,
	input wire logic       software_lock_mode
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// ==========================================
	// helpers
	logic [31:0] busy_cnt_reg;
	logic [31:0] busy_cnt_next;
	logic        commit;
	logic        prot_hit;
	assign busy_cnt_next = status_byte[0] ? busy_cnt_reg + 32'h1 : 32'h0;
	always_ff @(posedge sys_clk) begin
		busy_cnt_reg <= srst ? 32'h0 : busy_cnt_next;
	end
	assign commit = cmd.valid && cmd.kind inside {KIND_ARRAY_WRITE, KIND_ID_WRITE, KIND_ID_LOCK};
	assign prot_hit = (status_byte[3:2] == 2'h3)
		|| (status_byte[3:2] == 2'h2 && cmd.addr >= PROT_HALF_BASE)
		|| (status_byte[3:2] == 2'h1 && cmd.addr >= PROT_QUARTER_BASE);
	// ==========================================
	// assertions
	chk_reset_quiet: assert property (disable iff (1'b0)
		srst |=> status_byte == 8'h00 && !miso_oe && !cmd.valid) else $error("not quiet after reset");
	chk_spare_zero: assert property (status_byte[6:4] == 3'h0) else $error("spare bits set");
	chk_hard_lock: assert property ((status_byte[7] && !wp_n)[*4] |-> hardware_lock_mode)
		else $error("hardware lock missing");
	chk_soft_lock: assert property (software_lock_mode ==
		(status_byte[3:2] != 2'h0 && !hardware_lock_mode)) else $error("soft lock wrong");
	chk_busy_length: assert property ($fell(status_byte[0]) && !$past(srst) |->
		busy_cnt_reg >= 32'(WRITE_CYCLES_P - 1) && busy_cnt_reg <= 32'(WRITE_CYCLES_P + 1))
		else $error("busy length wrong");
	chk_done_latch: assert property ($fell(status_byte[0]) && !$past(srst) |-> !status_byte[1])
		else $error("latch kept after write");
	chk_prot_at_done: assert property ($changed({status_byte[7], status_byte[3:2]})
		&& !$past(srst) |-> $fell(status_byte[0])) else $error("protect bits moved");
	chk_latch_deselect: assert property ($rose(status_byte[1]) && !$past(srst) |-> cs_n)
		else $error("latch set while selected");
	chk_commit_latch: assert property (commit |-> status_byte[1] ##[0:2] status_byte[0])
		else $error("commit without latch or busy");
	chk_commit_region: assert property (commit && cmd.kind == KIND_ARRAY_WRITE |-> !prot_hit)
		else $error("write into protected region");
	chk_oe_selected: assert property ($rose(miso_oe) |-> !cs_n) else $error("output while idle");
	cov_busy: cover property ($rose(status_byte[0]));
	cov_commit: cover property (commit);
	cov_hard: cover property (hardware_lock_mode);
endmodule : secp_core_asserts

bind secp_core secp_core_asserts #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_secp_core_asserts (
	.sys_clk(sys_clk), .srst(srst), .cs_n(cs_n), .sck(sck), .mosi(mosi), .wp_n(wp_n),
	.miso(miso), .miso_oe(miso_oe), .cmd(cmd), .wr_byte(wr_byte), .rd_data(rd_data),
	.status_byte(status_byte), .hardware_lock_mode(hardware_lock_mode),
	.software_lock_mode(software_lock_mode));
`default_nettype wire

// [sim/secp_spi_master.sv]
// serial bus master model driving select, clock and data pins
`default_nettype none
module secp_spi_master (
	// clock
	input  wire logic sys_clk,
	// serial pins
	output var logic  cs_n,
	output var logic  sck,
	output var logic  mosi,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rx;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
		rx = '0;
	end
	// half of the 80 ns serial period, launched just after a system edge
	task automatic hp();
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : hp
	task automatic frame(input logic [31:0] bits, input int n);
		hp();
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = bits[i];
			hp();
			sck = 1'b1;
			hp();
			// sampled late in the high phase: output lags the falling edge by sync stages
			rx = {rx[30:0], miso};
			sck = 1'b0;
		end
		hp();
		cs_n = 1'b1;
		mosi = ~mosi;
		repeat (12) @(posedge sys_clk);
		#1;
	endtask : frame
endmodule : secp_spi_master
`default_nettype wire

// [sim/secp_tb_top.sv]
// self-checking testbench for the command and protection block
`default_nettype none
module secp_tb_top
	import secp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// short write cycle keeps the run brief
	localparam int WC = 400;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        wp_n = 1'b1;
	logic [7:0]  rd_data = 8'h5A;
	logic        cs_n, sck, mosi, miso, miso_oe, hw_lock, sw_lock;
	logic [7:0]  status_byte;
	secp_cmd_t   cmd;
	secp_byte_t  wr_byte;
	secp_kind_t  last_kind;
	logic [15:0] last_addr;
	logic [7:0]  last_wr = 8'h00;
	logic        oe_seen = 1'b0;
	int          n_cmd = 0;
	int          n_fail = 0;
	int          num_checks = 0;
	int          n0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (cmd.valid === 1'b1) begin
			last_kind <= cmd.kind;
			last_addr <= cmd.addr;
			n_cmd <= n_cmd + 1;
		end
		if (wr_byte.valid === 1'b1) begin
			last_wr <= wr_byte.data;
		end
		if (miso_oe === 1'b1) begin
			oe_seen <= 1'b1;
		end
	end
	secp_core #(.WRITE_CYCLES_P(WC), .ID_PAGE_EN(1'b1)) u_secp_core (
		.sys_clk(sys_clk), .srst(srst), .cs_n(cs_n), .sck(sck), .mosi(mosi), .wp_n(wp_n),
		.miso(miso), .miso_oe(miso_oe), .cmd(cmd), .wr_byte(wr_byte), .rd_data(rd_data),
		.status_byte(status_byte), .hardware_lock_mode(hw_lock), .software_lock_mode(sw_lock));
	secp_spi_master u_secp_spi_master (
		.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
	// ==========================================
	// tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
			n_fail++;
		end
	endtask : check
	task automatic xfer(input logic [31:0] bits, input int n);
		u_secp_spi_master.frame(bits, n);
	endtask : xfer
	task automatic wait_idle();
		for (int i = 0; i < WC + 50 && status_byte[0] !== 1'b0; i++) begin
			@(posedge sys_clk) #1;
		end
		check("busy cleared", 1'b0, status_byte[0]);
	endtask : wait_idle
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude
	// ==========================================
	// tests
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 srst = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		check("reset status", 8'h00, status_byte);
		xfer({8'h01, 8'h84}, 16);
		check("write unlatched", 8'h00, status_byte);
		xfer(8'h06, 8);
		check("latch set", 8'h02, status_byte);
		xfer(8'h04, 8);
		check("latch clear", 8'h00, status_byte);
		xfer(9'h00C, 9);
		check("latch set long", 8'h00, status_byte);
		xfer({8'hFF, 8'h06}, 16);
		check("bad opcode", 8'h00, status_byte);
		$display("test latch done");
		xfer(8'h06, 8);
		xfer({8'h01, 7'h42}, 15);
		check("short write", 8'h02, status_byte);
		xfer({8'h01, 8'h84, 1'b0}, 17);
		check("late deselect", 8'h02, status_byte);
		xfer({8'h01, 8'h84}, 16);
		check("write busy", 8'h03, status_byte);
		xfer({8'h05, 16'h0000}, 24);
		check("status read", 16'h0303, u_secp_spi_master.rx[15:0]);
		check("output enabled", 1'b1, oe_seen);
		check("output released", 1'b0, miso_oe);
		wait_idle();
		check("status written", 8'h84, status_byte);
		check("soft lock", 1'b1, sw_lock);
		$display("test status done");
		xfer(8'h06, 8);
		n0 = n_cmd;
		xfer({8'h02, 16'hC000, 8'h11}, 32);
		check("protected write", n0, n_cmd);
		xfer(8'h06, 8);
		xfer({8'h02, 16'hBFFF, 8'h22}, 32);
		check("write kind", KIND_ARRAY_WRITE, last_kind);
		check("write addr", 16'hBFFF, last_addr);
		check("write data", 8'h22, last_wr);
		check("array busy", 8'h87, status_byte);
		wait_idle();
		check("array done", 8'h84, status_byte);
		$display("test array done");
		wp_n = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		check("lock modes", 2'h2, {hw_lock, sw_lock});
		xfer(8'h06, 8);
		xfer({8'h01, 8'h00}, 16);
		check("locked write", 8'h86, status_byte);
		wp_n = 1'b1;
		xfer({8'h01, 8'h00}, 16);
		wait_idle();
		check("unlocked", 8'h00, status_byte);
		$display("test lock done");
		for (int i = 0; i < 2; i++) begin
			xfer(8'h06, 8);
			xfer({8'h82, 5'h00, i[0], 10'h000, 8'h33}, 32);
			check("id write", (i == 1) ? KIND_ID_LOCK : KIND_ID_WRITE, last_kind);
			wait_idle();
		end
		for (int i = 0; i < 3; i++) begin
			xfer({(i == 0) ? 8'h03 : 8'h83, (i == 2) ? 16'h0400 : 16'h0123, 8'h00}, 32);
			check("read kind", (i == 0) ? KIND_ARRAY_READ : ((i == 1) ? KIND_ID_READ
				: KIND_LOCK_STATUS), last_kind);
			check("read data", 8'h5A, u_secp_spi_master.rx[7:0]);
		end
		$display("test read done");
		conclude();
	end
	initial begin
		// the tests need about 5700 cycles; allow three and a half times that
		#200000;
		n_fail++;
		conclude();
	end
endmodule : secp_tb_top
`default_nettype wire
